/* File: hw/shcb_pkg.sv */
// Purpose: Shared constants and types for the sample history capture buffer
// Assumes: One clock domain, register port driven by the serial-bus engine
// Notes: Buffer order is chan0 voltage, chan0 current, chan1 voltage, chan1 current
package shcb_pkg;
    // Buffer geometry
    localparam int BUF_COUNT = 4;
    localparam int SAMPLE_W = 10;
    localparam int DEPTH = 50;
    localparam logic [5:0] DEPTH_LAST = 6'h31;
    // Register offsets
    localparam logic [7:0] ADDR_RUN_STOP = 8'h19;
    localparam logic [7:0] ADDR_RESOLUTION = 8'h3f;
    localparam logic [7:0] ADDR_STOP_DELAY = 8'h40;
    localparam logic [7:0] ADDR_PORT_CHAN0_VOLTAGE = 8'h46;
    localparam logic [7:0] ADDR_PORT_CHAN0_CURRENT = 8'h47;
    localparam logic [7:0] ADDR_PORT_CHAN1_VOLTAGE = 8'h48;
    localparam logic [7:0] ADDR_PORT_CHAN1_CURRENT = 8'h49;
    // Field positions, one bit per buffer in run/stop and resolution, then the stop delay MSB
    localparam int FLD_CHAN0_VOLTAGE = 0;
    localparam int FLD_CHAN0_CURRENT = 1;
    localparam int FLD_CHAN1_VOLTAGE = 2;
    localparam int FLD_CHAN1_CURRENT = 3;
    localparam int FLD_STOP_DELAY_MSB = 5;
    // Reset values and the stop delay clamp limit
    localparam logic [3:0] RUN_STOP_RESET = 4'hf;
    localparam logic [3:0] RESOLUTION_RESET = 4'hf;
    localparam logic [5:0] STOP_DELAY_RESET = 6'h19;
    localparam logic [5:0] STOP_DELAY_MAX = 6'h32;

    // One conversion result with the buffer it belongs to
    typedef struct packed {
        logic [1:0] sel;
        logic [SAMPLE_W-1:0] data;
    } shcb_sample_type;

    // Which byte of a full-resolution sample goes out next
    typedef enum logic {
        PH_HIGH = 1'b0,
        PH_LOW = 1'b1
    } shcb_phase_type;
endpackage : shcb_pkg

/* File: hw/shcb_capture.sv */
// Purpose: Four 50-deep sample history buffers with freeze and block readout
// Assumes: Inputs synchronous to CLK; one register access per REG_RD/REG_WR pulse
// Notes: Read data and status outputs are registered one cycle after the request
`timescale 1ns/10ps
module shcb_capture (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic SAMPLE_VALID,
    input shcb_pkg::shcb_sample_type SAMPLE,
    input wire logic [1:0] CHAN_FAULT_OFF,
    input wire logic [1:0] CHAN_SOFT_ENABLE_A,
    input wire logic [1:0] CHAN_SOFT_ENABLE_B,
    input wire logic [1:0] CHAN_ON_PIN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic REG_BLOCK_START,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    output logic [3:0] RECORD_RUN
);
    import shcb_pkg::*;

    logic [3:0] run; // Run bits, cleared by hardware when a buffer freezes
    logic [3:0] next_run;
    logic [3:0] byte_only; // Readout resolution per buffer
    logic [3:0] next_byte_only;
    logic [5:0] stop_delay; // Samples recorded after a shutdown
    logic [5:0] next_stop_delay;
    logic [1:0] chan_was_on; // Previous channel state for edge detect
    logic [1:0] chan_on; // Channel enabled and not faulted
    logic [1:0] shutdown_evt; // Channel just went off
    logic [5:0] delay_eff; // Stop delay clamped to the buffer depth
    logic [1:0] rd_sel; // Buffer being drained
    logic [1:0] next_rd_sel;
    logic [5:0] rd_idx; // Sample count from the oldest entry
    logic [5:0] next_rd_idx;
    shcb_phase_type rd_phase;
    shcb_phase_type next_rd_phase;
    logic [7:0] rdata; // Byte returned for this request
    logic rd_port; // Request addresses a buffer port
    logic [1:0] eff_sel; // Buffer selected by the current request
    logic [5:0] eff_idx; // Sample index used by the current request
    shcb_phase_type eff_phase;
    logic [SAMPLE_W-1:0] rd_word [BUF_COUNT]; // Per-buffer read word
    logic [BUF_COUNT-1:0] freeze_rd; // Block read started on this buffer
    logic wr_run; // Write to the run/stop register

    // Channel state and shutdown edge
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            chan_on[c] = CHAN_SOFT_ENABLE_A[c] & CHAN_SOFT_ENABLE_B[c] & CHAN_ON_PIN[c]
                & ~CHAN_FAULT_OFF[c];
        end
        shutdown_evt = chan_was_on & ~chan_on;
        // Values above the depth would outlive the history, so clamp them
        delay_eff = (stop_delay > STOP_DELAY_MAX) ? STOP_DELAY_MAX : stop_delay;
        wr_run = REG_WR && (REG_ADDR == ADDR_RUN_STOP);
    end

    // Control register writes
    always_comb begin
        next_byte_only = byte_only;
        next_stop_delay = stop_delay;
        if (REG_WR && (REG_ADDR == ADDR_RESOLUTION)) begin
            next_byte_only = REG_WDATA[FLD_CHAN1_CURRENT:FLD_CHAN0_VOLTAGE];
        end
        if (REG_WR && (REG_ADDR == ADDR_STOP_DELAY)) begin
            next_stop_delay = REG_WDATA[FLD_STOP_DELAY_MSB:0];
        end
    end

    // Control registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            byte_only <= RESOLUTION_RESET;
            stop_delay <= STOP_DELAY_RESET;
            chan_was_on <= 2'h0;
        end else begin
            byte_only <= next_byte_only;
            stop_delay <= next_stop_delay;
            chan_was_on <= chan_on;
        end
    end

    // Per-buffer recording, freeze and storage
    for (genvar i = 0; i < BUF_COUNT; i++) begin : buf_g
        localparam int CH = i / 2;
        logic [SAMPLE_W-1:0] mem [DEPTH]; // Sample storage
        logic [5:0] wptr; // Next slot to overwrite, also the oldest once full
        logic [5:0] next_wptr;
        logic full; // Every slot holds a sample
        logic next_full;
        logic pend; // Shutdown seen, post-delay still counting
        logic next_pend;
        logic [5:0] cnt; // Samples left before the freeze
        logic [5:0] next_cnt;
        logic delay_done;
        logic take; // Store this cycle's sample
        logic [6:0] slot_sum;
        logic [5:0] slot;

        // Next state of the recorder
        always_comb begin
            freeze_rd[i] = REG_RD && REG_BLOCK_START
                && (REG_ADDR == ADDR_PORT_CHAN0_VOLTAGE + 8'(i));
            delay_done = pend && (cnt == 6'h0);
            take = SAMPLE_VALID && (SAMPLE.sel == 2'(i)) && run[i] && !delay_done
                && !freeze_rd[i] && (chan_on[CH] || pend);
            next_run[i] = wr_run ? REG_WDATA[i] : run[i];
            // Hardware stop wins over a rearm in the same cycle
            if (freeze_rd[i] || delay_done) begin
                next_run[i] = 1'b0;
            end
            next_pend = pend;
            next_cnt = cnt;
            if (shutdown_evt[CH] && run[i] && !pend) begin
                next_pend = 1'b1;
                next_cnt = delay_eff;
            end else if (delay_done || !run[i]) begin
                next_pend = 1'b0;
            end else if (take && pend) begin
                next_cnt = cnt - 6'h1;
            end
            next_wptr = wptr;
            next_full = full;
            if (take) begin
                next_wptr = (wptr == DEPTH_LAST) ? 6'h0 : wptr + 6'h1;
                next_full = full | (wptr == DEPTH_LAST);
            end
            // Oldest retained sample is at wptr once full, else at zero
            slot_sum = {1'b0, (full ? wptr : 6'h0)} + {1'b0, eff_idx};
            slot = (slot_sum > 7'(DEPTH_LAST)) ? 6'(slot_sum - 7'(DEPTH)) : slot_sum[5:0];
            rd_word[i] = mem[slot];
        end

        // Recorder registers
        always_ff @(posedge CLK or negedge NRST) begin
            if (!NRST) begin
                run[i] <= RUN_STOP_RESET[i];
                pend <= 1'b0;
                cnt <= 6'h0;
                wptr <= 6'h0;
                full <= 1'b0;
            end else begin
                run[i] <= next_run[i];
                pend <= next_pend;
                cnt <= next_cnt;
                wptr <= next_wptr;
                full <= next_full;
            end
        end

        // Storage has no reset; slots not yet written read back stale data until the buffer is full
        always_ff @(posedge CLK) begin
            if (take) begin
                mem[wptr] <= SAMPLE.data;
            end
        end
    end

    // Readout pointer and byte selection
    always_comb begin
        rd_port = (REG_ADDR >= ADDR_PORT_CHAN0_VOLTAGE) && (REG_ADDR <= ADDR_PORT_CHAN1_CURRENT);
        eff_sel = 2'(REG_ADDR - ADDR_PORT_CHAN0_VOLTAGE);
        eff_idx = REG_BLOCK_START ? 6'h0 : rd_idx;
        eff_phase = REG_BLOCK_START ? PH_HIGH : rd_phase;
        next_rd_sel = rd_sel;
        next_rd_idx = rd_idx;
        next_rd_phase = rd_phase;
        rdata = 8'h0;
        if (REG_RD && rd_port) begin
            next_rd_sel = eff_sel;
            if (byte_only[eff_sel] || eff_phase == PH_LOW) begin
                // Wraps after the last sample so over-reads repeat history
                next_rd_idx = (eff_idx == DEPTH_LAST) ? 6'h0 : eff_idx + 6'h1;
                next_rd_phase = PH_HIGH;
            end else begin
                next_rd_idx = eff_idx;
                next_rd_phase = PH_LOW;
            end
            if (!byte_only[eff_sel] && eff_phase == PH_LOW) begin
                rdata = {6'h0, rd_word[eff_sel][1:0]};
            end else begin
                rdata = rd_word[eff_sel][SAMPLE_W-1:2];
            end
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                ADDR_RUN_STOP: rdata = {4'h0, run};
                ADDR_RESOLUTION: rdata = {4'h0, byte_only};
                ADDR_STOP_DELAY: rdata = {2'h0, stop_delay};
                default: rdata = 8'h0;
            endcase
        end
    end

    // Readout registers and outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rd_sel <= 2'h0;
            rd_idx <= 6'h0;
            rd_phase <= PH_HIGH;
            REG_RDATA <= 8'h0;
            REG_RVALID <= 1'b0;
            RECORD_RUN <= RUN_STOP_RESET;
        end else begin
            rd_sel <= next_rd_sel;
            rd_idx <= next_rd_idx;
            rd_phase <= next_rd_phase;
            REG_RDATA <= rdata;
            REG_RVALID <= REG_RD;
            RECORD_RUN <= next_run;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_start_c0v;
        REG_RD && REG_BLOCK_START && REG_ADDR == ADDR_PORT_CHAN0_VOLTAGE;
    endsequence

    AST_READ_FREEZES: assert property (s_start_c0v |=> !run[0] && !RECORD_RUN[0])
        else $error("Base read did not freeze buffer");
    AST_CLEAR_STOPS: assert property (wr_run && !REG_WDATA[2] |=> !run[2])
        else $error("Run bit clear ignored");
    AST_STOPPED_NO_WRITE: assert property (!run[2] |=> $stable(buf_g[2].wptr))
        else $error("Stopped buffer still recording");
    AST_OFF_NO_WRITE: assert property (!chan_on[0] && !buf_g[0].pend |=>
        $stable(buf_g[0].wptr))
        else $error("Off channel still recording");
    AST_ZERO_DELAY: assert property (shutdown_evt[0] && run[1] && !buf_g[1].pend
        && delay_eff == 6'h0 && !wr_run |=> ##1 !run[1])
        else $error("Zero stop delay did not stop buffer");
    AST_WRAP: assert property (buf_g[0].take && buf_g[0].wptr == DEPTH_LAST |=>
        buf_g[0].wptr == 6'h0 && buf_g[0].full)
        else $error("Write pointer did not wrap at fifty");
    AST_RESTART_FULL: assert property (s_start_c0v and !byte_only[0] |=>
        rd_phase == PH_LOW && rd_idx == 6'h0 && REG_RVALID)
        else $error("Block read did not restart pointer");
    // Last buffer port must land on the last buffer, not the reset default
    AST_SEL_TRACK: assert property (REG_RD && REG_BLOCK_START
        && REG_ADDR == ADDR_PORT_CHAN1_CURRENT |=> rd_sel == 2'h3)
        else $error("Block read selected wrong buffer");
    AST_LOW_PAD: assert property (REG_RD && rd_port && !byte_only[eff_sel]
        && eff_phase == PH_LOW |=> REG_RDATA[7:2] == 6'h0)
        else $error("Low byte upper bits not zero");
    AST_BYTE_STEP: assert property (REG_RD && rd_port && byte_only[eff_sel]
        && !REG_BLOCK_START && rd_idx < DEPTH_LAST |=> rd_idx == $past(rd_idx) + 6'h1)
        else $error("Byte-only read did not step one sample");
    AST_DELAY_RESET: assert property ($rose(NRST) |-> stop_delay == STOP_DELAY_RESET)
        else $error("Stop delay reset value wrong");
endmodule : shcb_capture

/* File: bench/shcb_host.sv */
// Purpose: Register-port host model that drains the history buffers
// Assumes: Requests launched at falling CLK, one access in flight
// Notes: Address and data are inverted when idle so stale values never match
`timescale 1ns/10ps
module shcb_host (
    input wire logic CLK,
    input wire logic [7:0] RDATA,
    input wire logic RVALID,
    output logic [7:0] ADDR,
    output logic WR,
    output logic [7:0] WDATA,
    output logic RD,
    output logic START
);
    // Quiet port at time zero
    initial begin
        ADDR = 8'h00;
        WR = 1'b0;
        WDATA = 8'h00;
        RD = 1'b0;
        START = 1'b0;
    end
    // One-cycle write pulse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        ADDR = a;
        WDATA = d;
        WR = 1'b1;
        @(negedge CLK);
        WR = 1'b0;
        ADDR = ~a;
        WDATA = ~d;
    endtask : wr
    // One byte; data without the valid flag is returned as unknown
    task automatic rd(input logic [7:0] a, input logic st, output logic [7:0] d);
        @(negedge CLK);
        ADDR = a;
        START = st;
        RD = 1'b1;
        @(negedge CLK);
        RD = 1'b0;
        START = 1'b0;
        ADDR = ~a;
        d = (RVALID === 1'b1) ? RDATA : 8'hxx;
    endtask : rd
endmodule : shcb_host

/* File: bench/shcb_capture_tb_top.sv */
// Purpose: Self-checking bench for the sample history capture buffer
// Assumes: Inputs change at falling CLK; expectations kept in queues
// Notes: Storage is unreset, so every buffer is filled before it is read
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module shcb_capture_tb_top;
    import shcb_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sample_valid = 1'b0;
    shcb_sample_type sample = '0;
    logic [1:0] fault_off = 2'b00;
    logic [1:0] soft_a = 2'b11;
    logic [1:0] soft_b = 2'b11;
    logic [1:0] on_pin = 2'b11;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic reg_wr, reg_rd, reg_start, reg_rvalid;
    logic [3:0] record_run;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [9:0] exp_q [4][$]; // Oldest first, at most DEPTH kept
    always #20 clk = ~clk;
    // Hang guard, far above the roughly 1200 cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            end_of_test();
        end
    end
    shcb_capture DUT (.CLK(clk), .NRST(nrst), .SAMPLE_VALID(sample_valid),
        .SAMPLE(sample), .CHAN_FAULT_OFF(fault_off), .CHAN_SOFT_ENABLE_A(soft_a),
        .CHAN_SOFT_ENABLE_B(soft_b), .CHAN_ON_PIN(on_pin), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
        .REG_BLOCK_START(reg_start), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .RECORD_RUN(record_run));
    shcb_host host (.CLK(clk), .RDATA(reg_rdata), .RVALID(reg_rvalid),
        .ADDR(reg_addr), .WR(reg_wr), .WDATA(reg_wdata), .RD(reg_rd),
        .START(reg_start));
    // Offer one sample; keep says whether the buffer should take it
    task automatic smp(input int b, input logic [9:0] d, input bit keep);
        @(negedge clk);
        sample = '{sel: 2'(b), data: d};
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        sample.data = ~d;
        if (keep) begin
            exp_q[b].push_back(d);
        end
        if (exp_q[b].size() > DEPTH) begin
            void'(exp_q[b].pop_front());
        end
    endtask : smp
    // Single register read against an expected byte
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, 1'b0, got);
        `CHK(got, e)
    endtask : chk_reg
    // Whole block read: 100 bytes in full mode, 50 in byte mode
    task automatic rd_buf(input int b, input bit full);
        logic [7:0] a;
        a = ADDR_PORT_CHAN0_VOLTAGE + 8'(b);
        for (int n = 0; n < DEPTH; n++) begin
            host.rd(a, n == 0, got);
            `CHK(got, exp_q[b][n][9:2])
            if (full) begin
                host.rd(a, 1'b0, got);
                `CHK(got, {6'h00, exp_q[b][n][1:0]})
            end
        end
    endtask : rd_buf
    // Verdict and end of run
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        `CHK(record_run, RUN_STOP_RESET)
        chk_reg(ADDR_RUN_STOP, 8'h0f);
        chk_reg(ADDR_RESOLUTION, 8'h0f);
        chk_reg(ADDR_STOP_DELAY, 8'h19);
        chk_reg(8'h50, 8'h00);
        host.wr(ADDR_STOP_DELAY, 8'h02);
        host.wr(ADDR_RESOLUTION, 8'h0e);
        // 55 rounds so every buffer wraps past its oldest slots
        for (int i = 0; i < 55; i++) begin
            for (int b = 0; b < BUF_COUNT; b++) begin
                smp(b, 10'(i * 37 + b * 101), 1'b1);
            end
        end
        rd_buf(0, 1'b1);
        `CHK(record_run[0], 1'b0)
        smp(0, 10'h155, 1'b0);
        rd_buf(0, 1'b1);
        host.wr(ADDR_RUN_STOP, 8'h0a);
        chk_reg(ADDR_RUN_STOP, 8'h0a);
        smp(2, 10'h2aa, 1'b0);
        rd_buf(2, 1'b0);
        // Fault on channel 1: two more samples land, then it freezes
        fault_off = 2'b10;
        for (int k = 0; k < 5; k++) begin
            smp(3, 10'(k * 3 + 1), k < 2);
        end
        repeat (4) @(negedge clk);
        `CHK(record_run[3], 1'b0)
        rd_buf(3, 1'b0);
        host.wr(ADDR_STOP_DELAY, 8'h00);
        on_pin = 2'b10;
        repeat (4) @(negedge clk);
        smp(1, 10'h0f0, 1'b0);
        `CHK(record_run[1], 1'b0)
        rd_buf(1, 1'b0);
        end_of_test();
    end
endmodule : shcb_capture_tb_top
